// >>> cpusf_defines.svh
// Register offsets, field positions, reset values and constants of the status flag bank.
`ifndef CPUSF_DEFINES_SVH
`define CPUSF_DEFINES_SVH

`define CPUSF_ADDR_W 8
`define CPUSF_OFF_ST0 8'h00
`define CPUSF_OFF_ST1 8'h04
`define CPUSF_OFF_IRQ_STAT 8'h08
`define CPUSF_OFF_IRQ_CLR 8'h0c
`define CPUSF_OFF_IRQ_EN 8'h10

`define CPUSF_ARP_HI 15
`define CPUSF_ARP_LO 13
`define CPUSF_OV_BIT 12
`define CPUSF_OVM_BIT 11
`define CPUSF_GLOBAL_IRQ_MASK_BIT 9
`define CPUSF_DP_HI 8
`define CPUSF_DP_LO 0
`define CPUSF_ARB_HI 15
`define CPUSF_ARB_LO 13
`define CPUSF_CNF_BIT 12
`define CPUSF_TC_BIT 11
`define CPUSF_SXM_BIT 10
`define CPUSF_C_BIT 9
`define CPUSF_XF_BIT 4
`define CPUSF_PM_HI 1
`define CPUSF_PM_LO 0
`define CPUSF_ST0_RSV 16'h0400
`define CPUSF_ST1_RSV 16'h01ec

`define CPUSF_RST_ARP 3'h0
`define CPUSF_RST_ARB 3'h0
`define CPUSF_RST_OV 1'h0
`define CPUSF_RST_OVM 1'h0
`define CPUSF_RST_GLOBAL_IRQ_MASK 1'h1
`define CPUSF_RST_DP 9'h000
`define CPUSF_RST_CNF 1'h0
`define CPUSF_RST_TC 1'h0
`define CPUSF_RST_SXM 1'h1
`define CPUSF_RST_C 1'h1
`define CPUSF_RST_XF 1'h1
`define CPUSF_RST_PM 2'h0

`define CPUSF_IRQ_W 3
`define CPUSF_IRQ_OV 0
`define CPUSF_IRQ_TRAP 1
`define CPUSF_IRQ_TC 2

`endif

// >>> cpusf_pkg.sv
// Types shared by the status flag bank and its users.
package cpusf_pkg;

	typedef enum logic [2:0] {
		CPUSF_FLAG_CARRY = 3'h0,
		CPUSF_FLAG_RAMMAP = 3'h1,
		CPUSF_FLAG_IRQMASK = 3'h2,
		CPUSF_FLAG_SAT = 3'h3,
		CPUSF_FLAG_SIGNEXT = 3'h4,
		CPUSF_FLAG_EXTPIN = 3'h5
	} cpusf_flag_t;

	typedef enum logic [1:0] {
		CPUSF_PS_NONE = 2'h0,
		CPUSF_PS_LEFT1 = 2'h1,
		CPUSF_PS_LEFT4 = 2'h2,
		CPUSF_PS_RIGHT6 = 2'h3
	} cpusf_pshift_t;

	typedef struct packed {
		logic st_load0;
		logic st_load1;
		logic [15:0] st_data;
		logic arp_wr;
		logic [2:0] arp_val;
		logic page_wr;
		logic [8:0] page_val;
		logic flag_set;
		logic flag_clear;
		cpusf_flag_t flag_sel;
		logic shift_mode_wr;
		logic [1:0] shift_mode_val;
		logic add_op;
		logic sub_op;
		logic shift16;
		logic carry_out;
		logic rot_op;
		logic rot_carry;
		logic alu_ovf;
		logic ov_branch;
		logic tc_upd;
		logic tc_val;
		logic int_ack;
		logic int_taken;
		logic [6:0] instr_low;
		logic [31:0] product;
	} cpusf_exec_t;

	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [7:0] paddr;
		logic [31:0] pwdata;
	} cpusf_apb_req_t;

endpackage

// >>> cpusf_flag_bank.sv
// Status and control flag bank of the CPU with an APB register window and interrupt.
`timescale 1ns/1ps
`include "cpusf_defines.svh"

// Behaviour
// - A new pointer value copies the old one into the buffer, except on status load.
// - Loading the buffer from the second status word also loads the pointer.
// - Pointer changes by indirect access, pointer load, modify-aux and status load.
// - Add carry sets carry, subtract borrow clears it, else the opposite.
// - With a 16-bit shift, add may only set and subtract may only clear carry.
// - Carry resets to 1; shifts, rotates, flag ops and second-word load update it.
// - RAM map select 0 maps RAM to data, 1 to program; reset clears it.
// - Direct address is the 9-bit page pointer joined to seven instruction bits.
// - Mask 1 blocks maskable interrupts; reset and non-maskable ones are unaffected.
// - Mask set by reset, acknowledge and trap; flag ops change it, status load not.
// - Overflow flag latches on ALU overflow until reset, overflow branch or status load.
// - Saturation enable selects wrap or clamp; flag ops and status load change it.
// - Product shift: none, left one, left four, right six sign-extended.
// - Shift only on the product path; set by shift-mode load and status load.
// - Sign-extend enable resets to 1 and steers the scaling shifter extension.
// - Test flag follows bit test, aux compare and normalize results.
// - External flag drives the output pin, set and cleared by flag ops, reset high.
// - Reserved bits of both status words read as one.
module cpusf_flag_bank (
	input wire logic mclk_i, // CPU clock, 10 MHz.
	input wire logic rst_b_i, // Asynchronous reset, active low.
	input wire cpusf_pkg::cpusf_exec_t exec_i, // Update requests from the pipeline.
	input wire logic int_req_i, // Maskable interrupt request.
	input wire cpusf_pkg::cpusf_apb_req_t apb_i, // APB request signals.
	output logic [31:0] prdata_o, // APB read data.
	output logic pready_o, // APB ready.
	output logic pslverr_o, // APB error for unmapped address.
	output logic irq_o, // Level interrupt to software.
	output logic [2:0] aux_reg_pointer_o, // Current auxiliary pointer.
	output logic [2:0] aux_pointer_buffer_o, // Previous auxiliary pointer.
	output logic carry_o, // Carry flag.
	output logic sticky_arith_flag_o, // Latched overflow flag.
	output logic saturation_enable_o, // Accumulator saturation mode.
	output logic sign_extend_enable_o, // Scaling shifter sign extension mode.
	output logic test_flag_o, // Test flag.
	output logic global_irq_mask_o, // Global maskable interrupt mask.
	output logic ram_map_select_o, // Dual-access RAM placement.
	output logic [8:0] page_pointer_o, // Data page pointer.
	output logic [1:0] product_shift_sel_o, // Product shift mode.
	output logic ext_flag_pin_o, // General purpose output pin.
	output logic int_grant_o, // Maskable interrupt passed by the mask.
	output logic [15:0] direct_addr_o, // Direct addressing address.
	output logic [31:0] scaled_product_o // Product as seen by the ALU.
);

	logic [2:0] arp_q;
	logic [2:0] arb_q;
	logic c_q;
	logic ov_q;
	logic ovm_q;
	logic sxm_q;
	logic tc_q;
	logic global_irq_mask_q;
	logic cnf_q;
	logic [8:0] dp_q;
	logic [1:0] pm_q;
	logic xf_q;
	logic grant_q;
	logic [15:0] daddr_q;
	logic [31:0] sprod_q;
	logic [31:0] prdata_q;
	logic pready_q;
	logic pslverr_q;
	logic [`CPUSF_IRQ_W-1:0] irq_stat_q;
	logic [`CPUSF_IRQ_W-1:0] irq_en_q;
	logic irq_q;

	logic setup;
	logic wr_fire;
	logic sw_ld0;
	logic sw_ld1;
	logic ld0;
	logic ld1;
	logic [15:0] ld_data;
	logic [`CPUSF_IRQ_W-1:0] irq_ev;
	logic [`CPUSF_IRQ_W-1:0] irq_clr;
	wire logic [`CPUSF_IRQ_W-1:0] irq_stat_d;

	function automatic logic flag_op(input cpusf_pkg::cpusf_exec_t e,
			input cpusf_pkg::cpusf_flag_t f, input logic set_not_clr);
		flag_op = (set_not_clr ? e.flag_set : e.flag_clear) && (e.flag_sel == f);
	endfunction

	function automatic logic mapped(input logic [7:0] a);
		case (a)
			`CPUSF_OFF_ST0, `CPUSF_OFF_ST1, `CPUSF_OFF_IRQ_STAT,
			`CPUSF_OFF_IRQ_CLR, `CPUSF_OFF_IRQ_EN: mapped = 1'b1;
			default: mapped = 1'b0;
		endcase
	endfunction

	function automatic logic wr_hit(input logic fire, input logic [7:0] a,
			input logic [7:0] off);
		wr_hit = fire && (a == off);
	endfunction

	function automatic logic [31:0] pshift(input logic [31:0] p, input logic [1:0] m);
		case (cpusf_pkg::cpusf_pshift_t'(m))
			cpusf_pkg::CPUSF_PS_NONE: pshift = p;
			cpusf_pkg::CPUSF_PS_LEFT1: pshift = {p[30:0], 1'b0};
			cpusf_pkg::CPUSF_PS_LEFT4: pshift = {p[27:0], 4'h0};
			cpusf_pkg::CPUSF_PS_RIGHT6: pshift = {{6{p[31]}}, p[31:6]};
			default: pshift = p;
		endcase
	endfunction

	function automatic logic [15:0] st0_img(input logic [2:0] aux_reg_pointer, input logic ov,
			input logic saturation_enable, input logic global_irq_mask, input logic [8:0] dp);
		logic [15:0] w;
		w = `CPUSF_ST0_RSV;
		w[`CPUSF_ARP_HI:`CPUSF_ARP_LO] = aux_reg_pointer;
		w[`CPUSF_OV_BIT] = ov;
		w[`CPUSF_OVM_BIT] = saturation_enable;
		w[`CPUSF_GLOBAL_IRQ_MASK_BIT] = global_irq_mask;
		w[`CPUSF_DP_HI:`CPUSF_DP_LO] = dp;
		st0_img = w;
	endfunction

	function automatic logic [15:0] st1_img(input logic [2:0] aux_pointer_buffer, input logic ram_map_select,
			input logic tc, input logic sign_extend_enable, input logic c, input logic xf,
			input logic [1:0] pm);
		logic [15:0] w;
		w = `CPUSF_ST1_RSV;
		w[`CPUSF_ARB_HI:`CPUSF_ARB_LO] = aux_pointer_buffer;
		w[`CPUSF_CNF_BIT] = ram_map_select;
		w[`CPUSF_TC_BIT] = tc;
		w[`CPUSF_SXM_BIT] = sign_extend_enable;
		w[`CPUSF_C_BIT] = c;
		w[`CPUSF_XF_BIT] = xf;
		w[`CPUSF_PM_HI:`CPUSF_PM_LO] = pm;
		st1_img = w;
	endfunction

	// A software write to a status word acts as a status load; the pipeline wins a collision.
	assign setup = apb_i.psel && !apb_i.penable;
	assign wr_fire = apb_i.psel && apb_i.penable && pready_q && apb_i.pwrite;
	assign sw_ld0 = wr_hit(wr_fire, apb_i.paddr, `CPUSF_OFF_ST0);
	assign sw_ld1 = wr_hit(wr_fire, apb_i.paddr, `CPUSF_OFF_ST1);
	assign ld0 = exec_i.st_load0 || (sw_ld0 && !exec_i.st_load1);
	assign ld1 = exec_i.st_load1 || (sw_ld1 && !exec_i.st_load0);
	assign ld_data = (exec_i.st_load0 || exec_i.st_load1) ? exec_i.st_data : apb_i.pwdata[15:0];

	always_ff @(posedge mclk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			arp_q <= `CPUSF_RST_ARP;
			arb_q <= `CPUSF_RST_ARB;
		end else if (ld1) begin
			arb_q <= ld_data[`CPUSF_ARB_HI:`CPUSF_ARB_LO];
			arp_q <= ld_data[`CPUSF_ARB_HI:`CPUSF_ARB_LO];
		end else if (ld0) begin
			arp_q <= ld_data[`CPUSF_ARP_HI:`CPUSF_ARP_LO];
		end else if (exec_i.arp_wr) begin
			arb_q <= arp_q;
			arp_q <= exec_i.arp_val;
		end
	end

	always_ff @(posedge mclk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			c_q <= `CPUSF_RST_C;
		end else if (ld1) begin
			c_q <= ld_data[`CPUSF_C_BIT];
		end else if (flag_op(exec_i, cpusf_pkg::CPUSF_FLAG_CARRY, 1'b1)) begin
			c_q <= 1'b1;
		end else if (flag_op(exec_i, cpusf_pkg::CPUSF_FLAG_CARRY, 1'b0)) begin
			c_q <= 1'b0;
		end else if (exec_i.rot_op) begin
			c_q <= exec_i.rot_carry;
		end else if (exec_i.add_op) begin
			c_q <= exec_i.shift16 ? (c_q | exec_i.carry_out) : exec_i.carry_out;
		end else if (exec_i.sub_op) begin
			c_q <= exec_i.shift16 ? (c_q & exec_i.carry_out) : exec_i.carry_out;
		end
	end

	// An overflow in the same cycle as a clearing operation keeps the flag set.
	always_ff @(posedge mclk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			ov_q <= `CPUSF_RST_OV;
		end else if (exec_i.alu_ovf) begin
			ov_q <= 1'b1;
		end else if (ld0) begin
			ov_q <= ld_data[`CPUSF_OV_BIT];
		end else if (exec_i.ov_branch) begin
			ov_q <= 1'b0;
		end
	end

	always_ff @(posedge mclk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			ovm_q <= `CPUSF_RST_OVM;
		end else if (ld0) begin
			ovm_q <= ld_data[`CPUSF_OVM_BIT];
		end else if (flag_op(exec_i, cpusf_pkg::CPUSF_FLAG_SAT, 1'b1)) begin
			ovm_q <= 1'b1;
		end else if (flag_op(exec_i, cpusf_pkg::CPUSF_FLAG_SAT, 1'b0)) begin
			ovm_q <= 1'b0;
		end
	end

	always_ff @(posedge mclk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			sxm_q <= `CPUSF_RST_SXM;
		end else if (ld1) begin
			sxm_q <= ld_data[`CPUSF_SXM_BIT];
		end else if (flag_op(exec_i, cpusf_pkg::CPUSF_FLAG_SIGNEXT, 1'b1)) begin
			sxm_q <= 1'b1;
		end else if (flag_op(exec_i, cpusf_pkg::CPUSF_FLAG_SIGNEXT, 1'b0)) begin
			sxm_q <= 1'b0;
		end
	end

	always_ff @(posedge mclk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			tc_q <= `CPUSF_RST_TC;
		end else if (ld1) begin
			tc_q <= ld_data[`CPUSF_TC_BIT];
		end else if (exec_i.tc_upd) begin
			tc_q <= exec_i.tc_val;
		end
	end

	// The status load leaves the mask alone; taking an interrupt beats a clear.
	always_ff @(posedge mclk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			global_irq_mask_q <= `CPUSF_RST_GLOBAL_IRQ_MASK;
		end else if (exec_i.int_ack || exec_i.int_taken) begin
			global_irq_mask_q <= 1'b1;
		end else if (flag_op(exec_i, cpusf_pkg::CPUSF_FLAG_IRQMASK, 1'b1)) begin
			global_irq_mask_q <= 1'b1;
		end else if (flag_op(exec_i, cpusf_pkg::CPUSF_FLAG_IRQMASK, 1'b0)) begin
			global_irq_mask_q <= 1'b0;
		end
	end

	always_ff @(posedge mclk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			cnf_q <= `CPUSF_RST_CNF;
		end else if (ld1) begin
			cnf_q <= ld_data[`CPUSF_CNF_BIT];
		end else if (flag_op(exec_i, cpusf_pkg::CPUSF_FLAG_RAMMAP, 1'b1)) begin
			cnf_q <= 1'b1;
		end else if (flag_op(exec_i, cpusf_pkg::CPUSF_FLAG_RAMMAP, 1'b0)) begin
			cnf_q <= 1'b0;
		end
	end

	always_ff @(posedge mclk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			dp_q <= `CPUSF_RST_DP;
		end else if (ld0) begin
			dp_q <= ld_data[`CPUSF_DP_HI:`CPUSF_DP_LO];
		end else if (exec_i.page_wr) begin
			dp_q <= exec_i.page_val;
		end
	end

	always_ff @(posedge mclk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			pm_q <= `CPUSF_RST_PM;
		end else if (ld1) begin
			pm_q <= ld_data[`CPUSF_PM_HI:`CPUSF_PM_LO];
		end else if (exec_i.shift_mode_wr) begin
			pm_q <= exec_i.shift_mode_val;
		end
	end

	always_ff @(posedge mclk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			xf_q <= `CPUSF_RST_XF;
		end else if (flag_op(exec_i, cpusf_pkg::CPUSF_FLAG_EXTPIN, 1'b1)) begin
			xf_q <= 1'b1;
		end else if (flag_op(exec_i, cpusf_pkg::CPUSF_FLAG_EXTPIN, 1'b0)) begin
			xf_q <= 1'b0;
		end
	end

	// Derived datapath values are registered so that every output leaves a flip-flop.
	always_ff @(posedge mclk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			grant_q <= 1'b0;
		end else begin
			grant_q <= int_req_i && !global_irq_mask_q;
		end
	end

	always_ff @(posedge mclk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			daddr_q <= 16'h0000;
		end else begin
			daddr_q <= {dp_q, exec_i.instr_low};
		end
	end

	always_ff @(posedge mclk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			sprod_q <= 32'h0000_0000;
		end else begin
			sprod_q <= pshift(exec_i.product, pm_q);
		end
	end

	// Interrupt status: set wins over a clear in the same cycle.
	assign irq_ev[`CPUSF_IRQ_OV] = exec_i.alu_ovf && !ov_q;
	assign irq_ev[`CPUSF_IRQ_TRAP] = exec_i.int_taken;
	assign irq_ev[`CPUSF_IRQ_TC] = exec_i.tc_upd && exec_i.tc_val;
	assign irq_clr = wr_hit(wr_fire, apb_i.paddr, `CPUSF_OFF_IRQ_CLR) ?
		apb_i.pwdata[`CPUSF_IRQ_W-1:0] : '0;

	for (genvar b = 0; b < `CPUSF_IRQ_W; b++) begin : g_irq_stat
		assign irq_stat_d[b] = irq_ev[b] || (irq_stat_q[b] && !irq_clr[b]);
	end

	always_ff @(posedge mclk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			irq_stat_q <= '0;
			irq_en_q <= '0;
			irq_q <= 1'b0;
		end else begin
			irq_stat_q <= irq_stat_d;
			if (wr_hit(wr_fire, apb_i.paddr, `CPUSF_OFF_IRQ_EN)) begin
				irq_en_q <= apb_i.pwdata[`CPUSF_IRQ_W-1:0];
			end
			irq_q <= |(irq_stat_q & irq_en_q);
		end
	end

	// APB slave: read data is captured in the setup cycle, ready in the first access cycle.
	always_ff @(posedge mclk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q <= 32'h0000_0000;
		end else begin
			pready_q <= setup;
			pslverr_q <= setup && !mapped(apb_i.paddr);
			if (setup && !apb_i.pwrite) begin
				case (apb_i.paddr)
					`CPUSF_OFF_ST0: prdata_q <= {16'h0000,
						st0_img(arp_q, ov_q, ovm_q, global_irq_mask_q, dp_q)};
					`CPUSF_OFF_ST1: prdata_q <= {16'h0000,
						st1_img(arb_q, cnf_q, tc_q, sxm_q, c_q, xf_q, pm_q)};
					`CPUSF_OFF_IRQ_STAT: prdata_q <= {29'h0, irq_stat_q};
					`CPUSF_OFF_IRQ_EN: prdata_q <= {29'h0, irq_en_q};
					default: prdata_q <= 32'h0000_0000;
				endcase
			end else begin
				prdata_q <= 32'h0000_0000;
			end
		end
	end

	assign prdata_o = prdata_q;
	assign pready_o = pready_q;
	assign pslverr_o = pslverr_q;
	assign irq_o = irq_q;
	assign aux_reg_pointer_o = arp_q;
	assign aux_pointer_buffer_o = arb_q;
	assign carry_o = c_q;
	assign sticky_arith_flag_o = ov_q;
	assign saturation_enable_o = ovm_q;
	assign sign_extend_enable_o = sxm_q;
	assign test_flag_o = tc_q;
	assign global_irq_mask_o = global_irq_mask_q;
	assign ram_map_select_o = cnf_q;
	assign page_pointer_o = dp_q;
	assign product_shift_sel_o = pm_q;
	assign ext_flag_pin_o = xf_q;
	assign int_grant_o = grant_q;
	assign direct_addr_o = daddr_q;
	assign scaled_product_o = sprod_q;

endmodule // cpusf_flag_bank

// >>> cpusf_flag_bank_assertions.sv
// Concurrent checks of the status flag bank, watching its ports only.
`timescale 1ns/1ps
`include "cpusf_defines.svh"
module cpusf_flag_bank_assertions (
	input wire logic mclk_i, // Clock.
	input wire logic rst_b_i, // Reset, active low.
	input wire cpusf_pkg::cpusf_exec_t exec_i, // Pipeline requests.
	input wire logic int_req_i, // Interrupt request.
	input wire cpusf_pkg::cpusf_apb_req_t apb_i, // APB request.
	input wire logic [31:0] prdata_o, // Read data.
	input wire logic pready_o, // Ready.
	input wire logic [2:0] aux_reg_pointer_o, // Pointer.
	input wire logic [2:0] aux_pointer_buffer_o, // Buffer.
	input wire logic carry_o, // Carry.
	input wire logic sticky_arith_flag_o, // Overflow flag.
	input wire logic global_irq_mask_o, // Mask.
	input wire logic ext_flag_pin_o, // Output pin.
	input wire logic int_grant_o, // Grant.
	input wire logic [8:0] page_pointer_o, // Page.
	input wire logic [15:0] direct_addr_o // Direct address.
);
	logic acc;
	logic st_any;
	logic fl_any;
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (!rst_b_i);
	// An APB write to either status word is a status load as well.
	assign acc = apb_i.psel & apb_i.penable & pready_o;
	assign st_any = exec_i.st_load0 | exec_i.st_load1 |
		(acc & apb_i.pwrite & apb_i.paddr[7:3] == 5'h00);
	assign fl_any = exec_i.flag_set | exec_i.flag_clear;
	sequence s_setup;
		apb_i.psel && !apb_i.penable;
	endsequence
	sequence s_access;
		apb_i.psel && apb_i.penable && pready_o;
	endsequence
	a_apb_ready: assert property (s_setup |=> s_access)
		else $error("no ready in the first access cycle");
	a_rsv_ones: assert property (s_access ##0 (!apb_i.pwrite && apb_i.paddr[7:3] == 5'h00) |->
		(prdata_o[15:0] & (apb_i.paddr[2] ? `CPUSF_ST1_RSV : `CPUSF_ST0_RSV)) ==
		(apb_i.paddr[2] ? `CPUSF_ST1_RSV : `CPUSF_ST0_RSV))
		else $error("reserved status bit read as zero");
	a_ptr_copy: assert property (exec_i.arp_wr && !st_any |=>
		aux_pointer_buffer_o == $past(aux_reg_pointer_o) && aux_reg_pointer_o == $past(exec_i.arp_val))
		else $error("pointer write did not move the old pointer to the buffer");
	a_ld1_both: assert property (exec_i.st_load1 |=>
		aux_reg_pointer_o == $past(exec_i.st_data[15:13]) && aux_pointer_buffer_o == aux_reg_pointer_o)
		else $error("second word load did not set pointer and buffer alike");
	a_carry_add: assert property (exec_i.add_op && !exec_i.shift16 && !exec_i.sub_op
		&& !exec_i.rot_op && !st_any && !fl_any |=> carry_o == $past(exec_i.carry_out))
		else $error("carry does not follow the add result");
	a_carry_hold: assert property (exec_i.add_op && exec_i.shift16 && !exec_i.carry_out
		&& !exec_i.sub_op && !exec_i.rot_op && !st_any && !fl_any |=> $stable(carry_o))
		else $error("shifted add without carry changed the carry");
	a_ov_latch: assert property (exec_i.alu_ovf |=> sticky_arith_flag_o)
		else $error("overflow flag not set after overflow");
	a_mask_set: assert property (exec_i.int_ack || exec_i.int_taken |=> global_irq_mask_o)
		else $error("mask not set by acknowledge or trap");
	a_load_keeps: assert property (st_any && !fl_any && !exec_i.int_ack && !exec_i.int_taken |=>
		$stable(global_irq_mask_o) && $stable(ext_flag_pin_o))
		else $error("status load changed mask or pin");
	a_direct_addr: assert property (1'h1 |=>
		direct_addr_o == {$past(page_pointer_o), $past(exec_i.instr_low)})
		else $error("direct address is not page and low bits");
	a_irq_grant: assert property (1'h1 |=> int_grant_o == $past(int_req_i && !global_irq_mask_o))
		else $error("grant does not follow request and mask");
endmodule // cpusf_flag_bank_assertions

bind cpusf_flag_bank cpusf_flag_bank_assertions cpusf_flag_bank_assertions_inst (.mclk_i, .rst_b_i,
	.exec_i, .int_req_i, .apb_i, .prdata_o, .pready_o, .aux_reg_pointer_o, .aux_pointer_buffer_o,
	.carry_o, .sticky_arith_flag_o, .global_irq_mask_o, .ext_flag_pin_o, .int_grant_o,
	.page_pointer_o, .direct_addr_o);

// >>> cpusf_pipe_model.sv
// Execute stage model that hands pipeline requests to the flag bank.
`timescale 1ns/1ps
module cpusf_pipe_model (
	input wire logic mclk_i, // CPU clock.
	input wire logic rst_b_i, // Reset, active low.
	input wire cpusf_pkg::cpusf_exec_t cmd_i, // Decoded request.
	output cpusf_pkg::cpusf_exec_t exec_o // Request in the execute stage.
);
	// Requests only change on an edge, as a real pipeline register would.
	always_ff @(posedge mclk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			exec_o <= '0;
		end else begin
			exec_o <= cmd_i;
		end
	end
endmodule // cpusf_pipe_model

// >>> cpusf_tb.sv
// Self-checking testbench of the status flag bank.
`timescale 1ns/1ps
`include "cpusf_defines.svh"
module tb;
	logic mclk_i = 1'h0;
	logic rst_b_i = 1'h0;
	logic int_req_i = 1'h0;
	cpusf_pkg::cpusf_exec_t cmd = '0;
	cpusf_pkg::cpusf_exec_t exec_i;
	cpusf_pkg::cpusf_exec_t e;
	cpusf_pkg::cpusf_apb_req_t apb_i = '0;
	logic [31:0] prdata_o, scaled_product_o, rd, r, xp;
	logic pready_o, pslverr_o, irq_o, carry_o, sticky_arith_flag_o, saturation_enable_o, er;
	logic sign_extend_enable_o, test_flag_o, global_irq_mask_o, ram_map_select_o, ext_flag_pin_o;
	logic int_grant_o, m_ov, m_tc;
	logic [2:0] aux_reg_pointer_o, aux_pointer_buffer_o, m_arp, m_arb;
	logic [8:0] page_pointer_o, m_dp;
	logic [1:0] product_shift_sel_o, m_pm;
	logic [15:0] direct_addr_o;
	logic [5:0] m_fl;
	int error_cnt = 0;
	int compares = 0;
	cpusf_flag_bank cpusf_flag_bank_inst (.mclk_i, .rst_b_i, .exec_i, .int_req_i, .apb_i, .prdata_o,
		.pready_o, .pslverr_o, .irq_o, .aux_reg_pointer_o, .aux_pointer_buffer_o, .carry_o,
		.sticky_arith_flag_o, .saturation_enable_o, .sign_extend_enable_o, .test_flag_o,
		.global_irq_mask_o, .ram_map_select_o, .page_pointer_o, .product_shift_sel_o,
		.ext_flag_pin_o, .int_grant_o, .direct_addr_o, .scaled_product_o);
	cpusf_pipe_model cpusf_pipe_model_inst (.mclk_i, .rst_b_i, .cmd_i(cmd), .exec_o(exec_i));
	task automatic end_of_test();
		$display("compares %0d error_cnt %0d", compares, error_cnt);
		if (error_cnt == 0 && compares > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	task automatic cmp(input logic [63:0] g, input logic [63:0] x, input string m);
		compares++;
		if (g !== x) begin
			error_cnt++;
			$display("MISMATCH %0t %s got %h exp %h", $time, m, g, x);
		end
	endtask
	task automatic chk(input string m);
		cmp({aux_reg_pointer_o, aux_pointer_buffer_o, ext_flag_pin_o, sign_extend_enable_o,
			saturation_enable_o, global_irq_mask_o, ram_map_select_o, carry_o,
			sticky_arith_flag_o, test_flag_o, page_pointer_o, product_shift_sel_o},
			{m_arp, m_arb, m_fl, m_ov, m_tc, m_dp, m_pm}, m);
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge mclk_i) apb_i <= '{1'h1, 1'h0, w, a, d};
		@(posedge mclk_i) apb_i.penable <= 1'h1;
		do begin
			@(posedge mclk_i);
			n++;
		end while (pready_o !== 1'h1 && n < 20);
		rd = prdata_o;
		er = pslverr_o;
		apb_i <= '0;
		if (n >= 20) cmp(0, 1, "apb timeout");
		#1;
	endtask
	task automatic rd_st();
		apb(1'h0, `CPUSF_OFF_ST0, 32'h0);
		cmp(rd, {m_arp, m_ov, m_fl[3], 1'h1, m_fl[2], m_dp}, "st0");
		apb(1'h0, `CPUSF_OFF_ST1, 32'h0);
		cmp(rd, {m_arb, m_fl[1], m_tc, m_fl[4], m_fl[0], 4'hf, m_fl[5], 2'h3, m_pm}, "st1");
	endtask
	// The model is updated one edge after issue, in the execute stage; one request kind per call, except a mask clear beside a test flag update.
	task automatic ex(input cpusf_pkg::cpusf_exec_t x);
		cpusf_pkg::cpusf_exec_t i;
		i = '0;
		i.instr_low = x.instr_low;
		i.product = x.product;
		@(posedge mclk_i) cmd <= x;
		@(posedge mclk_i) cmd <= i;
		if (x.st_load1) begin
			{m_arb, m_fl[1], m_tc, m_fl[4], m_fl[0]} = x.st_data[15:9];
			m_arp = x.st_data[15:13];
			m_pm = x.st_data[1:0];
		end
		if (x.st_load0) begin
			{m_arp, m_ov, m_fl[3]} = x.st_data[15:11];
			m_dp = x.st_data[8:0];
		end
		if (x.arp_wr) {m_arb, m_arp} = {m_arp, x.arp_val};
		if (x.page_wr) m_dp = x.page_val;
		if (x.flag_set | x.flag_clear) m_fl[x.flag_sel] = x.flag_set;
		if (x.shift_mode_wr) m_pm = x.shift_mode_val;
		if (x.add_op) m_fl[0] = x.shift16 ? (m_fl[0] | x.carry_out) : x.carry_out;
		if (x.sub_op) m_fl[0] = x.shift16 ? (m_fl[0] & x.carry_out) : x.carry_out;
		if (x.rot_op) m_fl[0] = x.rot_carry;
		if (x.ov_branch) m_ov = 1'h0;
		if (x.alu_ovf) m_ov = 1'h1;
		if (x.tc_upd) m_tc = x.tc_val;
		if (x.int_ack | x.int_taken) m_fl[2] = 1'h1;
		repeat (2) @(posedge mclk_i);
		#1;
	endtask
	initial begin
		forever #50 mclk_i = ~mclk_i;
	end
	initial begin
		#1ms;
		error_cnt++;
		end_of_test();
	end
	initial begin
		void'($urandom(88711));
		{m_fl, m_arp, m_arb, m_dp, m_pm, m_ov, m_tc} = {6'h35, 19'h0};
		repeat (12) @(posedge mclk_i);
		rst_b_i <= 1'h1;
		@(posedge mclk_i);
		#1;
		chk("reset");
		rd_st();
		for (int k = 0; k < 4; k++) begin
			r = $urandom;
			e = '0;
			e.arp_wr = 1'h1;
			e.arp_val = r[2:0];
			ex(e);
			chk("pointer write");
		end
		for (int k = 0; k < 2; k++) begin
			r = $urandom;
			e = '0;
			e.st_load1 = ~k[0];
			e.st_load0 = k[0];
			e.st_data = r[15:0];
			ex(e);
			chk("status load");
			rd_st();
		end
		r = $urandom;
		apb(1'h1, `CPUSF_OFF_ST1, r);
		{m_arb, m_fl[1], m_tc, m_fl[4], m_fl[0]} = r[15:9];
		{m_arp, m_pm} = {r[15:13], r[1:0]};
		chk("software load one");
		r = $urandom;
		apb(1'h1, `CPUSF_OFF_ST0, r);
		{m_arp, m_ov, m_fl[3]} = r[15:11];
		m_dp = r[8:0];
		chk("software load zero");
		for (int k = 0; k < 12; k++) begin
			e = '0;
			e.flag_set = k[0];
			e.flag_clear = ~k[0];
			e.flag_sel = cpusf_pkg::cpusf_flag_t'(k / 2);
			ex(e);
			chk("flag op");
		end
		for (int k = 0; k < 18; k++) begin
			e = '0;
			e.flag_set = k[3];
			e.flag_clear = ~k[3];
			ex(e);
			r = $urandom;
			e = '0;
			e.add_op = ~k[2] & ~k[4];
			e.sub_op = k[2] & ~k[4];
			e.shift16 = k[1];
			e.carry_out = k[0];
			e.rot_op = k[4];
			e.rot_carry = r[0];
			ex(e);
			chk("carry");
		end
		for (int k = 0; k < 3; k++) begin
			e = '0;
			e.alu_ovf = k == 0;
			e.ov_branch = k == 2;
			ex(e);
			chk("overflow");
		end
		r = $urandom;
		e = '0;
		e.page_wr = 1'h1;
		e.page_val = r[8:0];
		e.instr_low = r[15:9];
		ex(e);
		chk("page");
		cmp(direct_addr_o, {m_dp, r[15:9]}, "direct address");
		r = $urandom;
		for (int k = 0; k < 4; k++) begin
			e = '0;
			e.product = r;
			e.shift_mode_wr = 1'h1;
			e.shift_mode_val = k[1:0];
			ex(e);
			xp = k == 0 ? r : k == 1 ? r << 1 : k == 2 ? r << 4 : 32'($signed(r) >>> 6);
			cmp(scaled_product_o, xp, "product shift");
		end
		for (int k = 0; k < 4; k++) begin
			e = '0;
			e.tc_upd = 1'h1;
			e.tc_val = ~k[0];
			e.flag_clear = k == 1;
			e.flag_sel = cpusf_pkg::CPUSF_FLAG_IRQMASK;
			ex(e);
			chk("test flag");
		end
		@(posedge mclk_i) int_req_i <= 1'h1;
		repeat (2) @(posedge mclk_i);
		#1;
		cmp(int_grant_o, 1'h1, "grant open");
		e = '0;
		e.int_ack = 1'h1;
		ex(e);
		chk("acknowledge");
		cmp(int_grant_o, 1'h0, "grant masked");
		apb(1'h1, `CPUSF_OFF_IRQ_CLR, 32'h7);
		apb(1'h1, `CPUSF_OFF_IRQ_EN, 32'h2);
		e = '0;
		e.int_taken = 1'h1;
		ex(e);
		chk("trap");
		cmp(irq_o, 1'h1, "irq raised");
		apb(1'h0, `CPUSF_OFF_IRQ_STAT, 32'h0);
		cmp(rd, 32'h2, "irq status");
		apb(1'h1, `CPUSF_OFF_IRQ_CLR, 32'h2);
		repeat (2) @(posedge mclk_i);
		#1;
		cmp(irq_o, 1'h0, "irq cleared");
		apb(1'h1, `CPUSF_OFF_IRQ_EN, 32'h0);
		e = '0;
		e.tc_upd = 1'h1;
		e.tc_val = 1'h1;
		ex(e);
		cmp(irq_o, 1'h0, "irq disabled");
		apb(1'h0, `CPUSF_OFF_IRQ_STAT, 32'h0);
		cmp(rd, 32'h4, "masked status");
		apb(1'h0, `CPUSF_OFF_IRQ_CLR, 32'h0);
		cmp({er, rd}, 33'h0, "clear reads zero");
		apb(1'h1, 8'h20, 32'hffff);
		cmp(er, 1'h1, "unmapped write");
		end_of_test();
	end
endmodule // tb
